/* shared/addr_dec_pkg.sv */
package addr_dec_pkg;
    // ****************************************
    // Address byte layout
    // ****************************************
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int HWADDR_MSB = 3;
    localparam int HWADDR_LSB = 1;
    localparam int RW_POS = 0;
    localparam logic [3:0] TYPE_ARRAY = 4'hA;
    localparam logic [3:0] TYPE_SECURE = 4'hB;
    localparam logic [6:0] MC_MFG_ID = 7'h7C;
    localparam logic [4:0] MC_HS_PREFIX = 5'h01;
    // ****************************************
    // Word address layout and bit counter values
    // ****************************************
    localparam int REGION_SELECT_MSB_POS = 7;
    localparam int REGION_CODE_HI_POS = 3;
    localparam int REGION_CODE_LO_POS = 2;
    localparam logic [1:0] REGION_CODE_SECURE = 2'h2;
    localparam logic [3:0] LOCK_CODE = 4'h6;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [15:0] WORD_ADDR_RESET = 16'h0000;

    typedef enum logic [2:0] {
        REGION_NONE,
        REGION_ARRAY,
        REGION_SECURITY,
        REGION_CONFIG,
        REGION_LOCK
    } region_t;

    typedef enum logic [1:0] {
        MC_NONE,
        MC_MFG,
        MC_HS
    } master_code_t;
endpackage

/* shared/bus_events_if.sv */
interface bus_events_if;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic sda_level;
    logic scl_level;
    logic bus_idle;
    modport producer(output start_seen, output stop_seen, output scl_rise, output scl_fall,
                     output sda_level, output scl_level, output bus_idle);
    modport consumer(input start_seen, input stop_seen, input scl_rise, input scl_fall,
                     input sda_level, input scl_level, input bus_idle);
endinterface

/* logic/line_watch.sv */
module line_watch (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_pin,
    input wire logic sda_pin,
    bus_events_if.producer ev
);
    logic [1:0] scl_sync_q, scl_sync_d;
    logic [1:0] sda_sync_q, sda_sync_d;
    logic scl_prev_q, scl_prev_d;
    logic sda_prev_q, sda_prev_d;

    always_comb begin
        scl_sync_d = {scl_sync_q[0], scl_pin};
        sda_sync_d = {sda_sync_q[0], sda_pin};
        scl_prev_d = scl_sync_q[1];
        sda_prev_d = sda_sync_q[1];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
        end
    end

    assign ev.scl_level = scl_prev_q;
    assign ev.sda_level = sda_prev_q;
    assign ev.scl_rise = scl_sync_q[1] && !scl_prev_q;
    assign ev.scl_fall = !scl_sync_q[1] && scl_prev_q;
    // Clock held high on both samples, so a data edge is a condition
    assign ev.start_seen = scl_sync_q[1] && scl_prev_q && !sda_sync_q[1] && sda_prev_q;
    assign ev.stop_seen = scl_sync_q[1] && scl_prev_q && sda_sync_q[1] && !sda_prev_q;
    assign ev.bus_idle = scl_prev_q && sda_prev_q;

    start_clean_a: assert property (@(posedge clk) disable iff (!resetn)
        ev.start_seen |-> !ev.stop_seen && $past(ev.sda_level) && !ev.scl_fall)
        else $error("start flagged with wrong line levels");
    stop_clean_a: assert property (@(posedge clk) disable iff (!resetn)
        ev.stop_seen |=> ev.sda_level && ev.scl_level)
        else $error("stop flagged with wrong line levels");
endmodule

/* logic/addr_decoder.sv */
module addr_decoder (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic STRAP_ADDR_BIT0,
    input wire logic STRAP_ADDR_BIT1,
    input wire logic STRAP_ADDR_BIT2,
    output logic SELECTED,
    output logic READ_NWRITE,
    output logic [2:0] REGION,
    output logic [15:0] WORD_ADDR,
    output logic ADDR_VALID,
    output logic ACCESS_FAIL,
    output logic MFG_ID_REQ,
    output logic HIGH_SPEED_ENTRY,
    output logic BUS_BUSY
);
    // ****************************************
    // Line sampling
    // ****************************************
    bus_events_if ev ();

    line_watch u_watch (
        .clk(CLK),
        .resetn(RESETN),
        .scl_pin(SCL_IN),
        .sda_pin(SDA_IN),
        .ev(ev)
    );

    // ****************************************
    // Byte sequencer
    // ****************************************
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_DEV_ADDR,
        ST_WORD_HI,
        ST_WORD_LO,
        ST_DATA
    } phase_t;

    phase_t phase_q, phase_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic ack_pend_q, ack_pend_d;
    logic drive_q, drive_d;
    logic selected_q, selected_d;
    logic rnw_q, rnw_d;
    addr_dec_pkg::region_t region_q, region_d;
    logic [15:0] waddr_q, waddr_d;
    logic valid_q, valid_d;
    logic fail_q, fail_d;
    addr_dec_pkg::master_code_t mc_q, mc_d;
    logic array_open_q, array_open_d;
    logic busy_q, busy_d;
    logic [7:0] byte_in;
    logic [2:0] strap;

    function automatic logic type_ok(input logic [7:0] b);
        return b[addr_dec_pkg::TYPE_MSB:addr_dec_pkg::TYPE_LSB] == addr_dec_pkg::TYPE_ARRAY ||
               b[addr_dec_pkg::TYPE_MSB:addr_dec_pkg::TYPE_LSB] == addr_dec_pkg::TYPE_SECURE;
    endfunction

    function automatic addr_dec_pkg::region_t secure_region(input logic [7:0] hi);
        if (hi[3:0] == addr_dec_pkg::LOCK_CODE)
            return addr_dec_pkg::REGION_LOCK;
        if ({hi[addr_dec_pkg::REGION_CODE_HI_POS], hi[addr_dec_pkg::REGION_CODE_LO_POS]}
            == addr_dec_pkg::REGION_CODE_SECURE)
            return hi[addr_dec_pkg::REGION_SELECT_MSB_POS] ? addr_dec_pkg::REGION_CONFIG
                                                           : addr_dec_pkg::REGION_SECURITY;
        return addr_dec_pkg::REGION_NONE;
    endfunction

    assign strap = {STRAP_ADDR_BIT2, STRAP_ADDR_BIT1, STRAP_ADDR_BIT0};
    assign byte_in = {shift_q[6:0], ev.sda_level};

    always_comb begin
        phase_d = phase_q;
        bit_d = bit_q;
        shift_d = shift_q;
        ack_pend_d = ack_pend_q;
        drive_d = drive_q;
        selected_d = selected_q;
        rnw_d = rnw_q;
        region_d = region_q;
        waddr_d = waddr_q;
        valid_d = valid_q;
        fail_d = fail_q;
        mc_d = mc_q;
        array_open_d = array_open_q;
        busy_d = busy_q;
        if (ev.start_seen) begin
            // Restart from any phase; a repeated start keeps master-code context
            phase_d = ST_DEV_ADDR;
            bit_d = 4'h0;
            ack_pend_d = 1'b1; // Next clock fall opens bit 0 and ends no bit
            drive_d = 1'b0;
            valid_d = 1'b0;
            fail_d = 1'b0;
            selected_d = 1'b0;
            busy_d = 1'b1;
        end else if (ev.stop_seen) begin
            phase_d = ST_STANDBY;
            drive_d = 1'b0;
            ack_pend_d = 1'b0;
            selected_d = 1'b0;
            busy_d = 1'b0;
            mc_d = addr_dec_pkg::MC_NONE;
            array_open_d = 1'b0;
        end else if (phase_q != ST_STANDBY) begin
            if (ev.scl_rise && bit_q <= addr_dec_pkg::BIT_LAST) begin
                shift_d = byte_in;
            end
            if (ev.scl_fall) begin
                if (ack_pend_q) begin
                    // Falling edge after the ninth pulse releases data
                    ack_pend_d = 1'b0;
                    drive_d = 1'b0;
                    bit_d = 4'h0;
                end else if (bit_q == addr_dec_pkg::BIT_LAST) begin
                    bit_d = addr_dec_pkg::BIT_ACK;
                    ack_pend_d = 1'b1;
                    unique case (phase_q)
                        ST_DEV_ADDR: begin
                            if (shift_q[7:1] == addr_dec_pkg::MC_MFG_ID) begin
                                mc_d = addr_dec_pkg::MC_MFG;
                                rnw_d = shift_q[addr_dec_pkg::RW_POS];
                                drive_d = 1'b1;
                                phase_d = ST_DEV_ADDR;
                            end else if (shift_q[7:3] == addr_dec_pkg::MC_HS_PREFIX) begin
                                // High-speed code is never acknowledged
                                mc_d = addr_dec_pkg::MC_HS;
                                phase_d = ST_DEV_ADDR;
                            end else if (type_ok(shift_q) &&
                                         shift_q[addr_dec_pkg::HWADDR_MSB:addr_dec_pkg::HWADDR_LSB] == strap) begin
                                selected_d = 1'b1;
                                drive_d = 1'b1;
                                rnw_d = shift_q[addr_dec_pkg::RW_POS];
                                region_d = shift_q[4] ? addr_dec_pkg::REGION_NONE : addr_dec_pkg::REGION_ARRAY;
                                if (!shift_q[4])
                                    array_open_d = 1'b1;
                                if (shift_q[addr_dec_pkg::RW_POS]) begin
                                    // Current-address read: word address is kept
                                    phase_d = ST_DATA;
                                    valid_d = !shift_q[4];
                                end else begin
                                    phase_d = ST_WORD_HI;
                                end
                            end else begin
                                phase_d = ST_STANDBY;
                                ack_pend_d = 1'b0;
                                mc_d = addr_dec_pkg::MC_NONE;
                            end
                        end
                        ST_WORD_HI: begin
                            drive_d = 1'b1;
                            waddr_d[15:8] = shift_q;
                            if (region_q != addr_dec_pkg::REGION_ARRAY)
                                region_d = secure_region(shift_q);
                            phase_d = ST_WORD_LO;
                        end
                        ST_WORD_LO: begin
                            drive_d = 1'b1;
                            // Low byte is don't-care for config and lock
                            waddr_d[7:0] = (region_q == addr_dec_pkg::REGION_CONFIG ||
                                            region_q == addr_dec_pkg::REGION_LOCK) ? 8'h00 : shift_q;
                            valid_d = 1'b1;
                            fail_d = region_q != addr_dec_pkg::REGION_ARRAY && array_open_q;
                            phase_d = ST_DATA;
                        end
                        ST_DATA: begin
                            drive_d = !rnw_q;
                        end
                        default: begin
                            phase_d = ST_STANDBY;
                        end
                    endcase
                end else begin
                    bit_d = bit_q + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            phase_q <= ST_STANDBY;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ack_pend_q <= 1'b0;
            drive_q <= 1'b0;
            selected_q <= 1'b0;
            rnw_q <= 1'b0;
            region_q <= addr_dec_pkg::REGION_NONE;
            waddr_q <= addr_dec_pkg::WORD_ADDR_RESET;
            valid_q <= 1'b0;
            fail_q <= 1'b0;
            mc_q <= addr_dec_pkg::MC_NONE;
            array_open_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            ack_pend_q <= ack_pend_d;
            drive_q <= drive_d;
            selected_q <= selected_d;
            rnw_q <= rnw_d;
            region_q <= region_d;
            waddr_q <= waddr_d;
            valid_q <= valid_d;
            fail_q <= fail_d;
            mc_q <= mc_d;
            array_open_q <= array_open_d;
            busy_q <= busy_d;
        end
    end

    // Open drain: only ever pull low
    assign SDA_OUT = 1'b0;
    assign SDA_OE = drive_q;
    assign SELECTED = selected_q;
    assign READ_NWRITE = rnw_q;
    assign REGION = region_q;
    assign WORD_ADDR = waddr_q;
    assign ADDR_VALID = valid_q;
    assign ACCESS_FAIL = fail_q;
    assign MFG_ID_REQ = mc_q == addr_dec_pkg::MC_MFG ? 1'b1 : 1'b0;
    assign HIGH_SPEED_ENTRY = mc_q == addr_dec_pkg::MC_HS ? 1'b1 : 1'b0;
    assign BUS_BUSY = busy_q;

    // ****************************************
    // Checks
    // ****************************************
    start_restart_a: assert property (@(posedge CLK) disable iff (!RESETN)
        ev.start_seen |=> phase_q == ST_DEV_ADDR && bit_q == 4'h0 && !SDA_OE)
        else $error("start did not restart address reception");
    stop_standby_a: assert property (@(posedge CLK) disable iff (!RESETN)
        ev.stop_seen |=> phase_q == ST_STANDBY && !SDA_OE && !SELECTED)
        else $error("stop did not return to standby");
    standby_quiet_a: assert property (@(posedge CLK) disable iff (!RESETN)
        phase_q == ST_STANDBY && !ev.start_seen |=> phase_q == ST_STANDBY)
        else $error("left standby without start");
    ack_ninth_a: assert property (@(posedge CLK) disable iff (!RESETN)
        SDA_OE |-> bit_q == addr_dec_pkg::BIT_ACK)
        else $error("data driven outside ack slot");
    mismatch_nack_a: assert property (@(posedge CLK) disable iff (!RESETN)
        phase_q == ST_DEV_ADDR && ev.scl_fall && bit_q == addr_dec_pkg::BIT_LAST && !ack_pend_q
        && !ev.start_seen && !ev.stop_seen && !type_ok(shift_q) && shift_q[7:3] != addr_dec_pkg::MC_HS_PREFIX
        && shift_q[7:1] != addr_dec_pkg::MC_MFG_ID |=> phase_q == ST_STANDBY && !SDA_OE)
        else $error("mismatched address acknowledged");
    rw_capture_a: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(SELECTED) |-> READ_NWRITE == $past(shift_q[0]))
        else $error("read/write select not captured");
    strap_match_a: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(SELECTED) |-> $past(shift_q[3:1]) == $past(strap))
        else $error("selected with wrong hardware address");
    fail_open_a: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(ACCESS_FAIL) |-> REGION != addr_dec_pkg::REGION_ARRAY && $past(array_open_q))
        else $error("access failed without open array sequence");
    hs_nack_a: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(HIGH_SPEED_ENTRY) |-> !SDA_OE)
        else $error("high-speed code acknowledged");
    idle_after_stop_a: assert property (@(posedge CLK) disable iff (!RESETN)
        ev.stop_seen |=> ev.bus_idle && !BUS_BUSY)
        else $error("bus not idle after stop");

    cov_select_c: cover property (@(posedge CLK) disable iff (!RESETN) $rose(SELECTED));
    cov_valid_c: cover property (@(posedge CLK) disable iff (!RESETN) $rose(ADDR_VALID));
    cov_fail_c: cover property (@(posedge CLK) disable iff (!RESETN) $rose(ACCESS_FAIL));
    cov_mfg_c: cover property (@(posedge CLK) disable iff (!RESETN) $rose(MFG_ID_REQ));
endmodule

/* dv/i2c_master_model.sv */
module i2c_master_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;

    // Both lines released means idle, and the clock stays parked high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ****************************************
    // Bit level: 800 ns link period
    // ****************************************
    // Data only moves in the middle of clock low; only this model drives the clock
    task automatic put_bit(input logic b, output logic seen);
        scl = 1'b0;
        wait_clk(2);
        sda_low = ~b;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(2);
        seen = sda_wire;
        wait_clk(2);
    endtask

    // Skip the clock-low setup when the bus is already idle so idle stays still
    task automatic start_cond();
        if (!(scl && sda_wire)) begin
            scl = 1'b0;
            wait_clk(2);
            sda_low = 1'b0;
            wait_clk(2);
            scl = 1'b1;
            wait_clk(2);
        end
        sda_low = 1'b1;
        wait_clk(4);
    endtask

    task automatic stop_cond();
        scl = 1'b0;
        wait_clk(2);
        sda_low = 1'b1;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(2);
        sda_low = 1'b0;
        wait_clk(6);
    endtask

    // Eight bits MSB first, then a released ninth pulse for the acknowledge
    task automatic put_byte(input logic [7:0] v, output logic acked);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i], seen);
        end
        put_bit(1'b1, seen);
        acked = ~seen;
    endtask
endmodule

/* dv/tb_eeprom_i2c_address_decoder.sv */
module tb_eeprom_i2c_address_decoder;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic resetn;
    logic [2:0] strap;
    logic scl;
    logic sda_low;
    logic sda_wire;
    logic sda_out;
    logic sda_oe;
    logic selected;
    logic rnw;
    logic [2:0] region;
    logic [15:0] word_addr;
    logic addr_valid;
    logic access_fail;
    logic mfg;
    logic hs;
    logic busy;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] hi_tab [3] = '{8'h08, 8'h88, 8'h06};
    logic [2:0] reg_tab [3] = '{addr_dec_pkg::REGION_SECURITY, addr_dec_pkg::REGION_CONFIG,
                                addr_dec_pkg::REGION_LOCK};
    logic [15:0] wa_tab [3] = '{16'h0880, 16'h8800, 16'h0600};

    // Open-drain data line with pull-up
    assign sda_wire = ~(sda_low | sda_oe);

    addr_decoder dut (
        .CLK(clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda_wire),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .STRAP_ADDR_BIT0(strap[0]), .STRAP_ADDR_BIT1(strap[1]), .STRAP_ADDR_BIT2(strap[2]),
        .SELECTED(selected), .READ_NWRITE(rnw), .REGION(region), .WORD_ADDR(word_addr),
        .ADDR_VALID(addr_valid), .ACCESS_FAIL(access_fail), .MFG_ID_REQ(mfg),
        .HIGH_SPEED_ENTRY(hs), .BUS_BUSY(busy)
    );

    i2c_master_model m (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic give_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] v, input logic exp_ack);
        logic ack;
        m.put_byte(v, ack);
        chk("ack", 16'(ack), 16'(exp_ack));
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        strap = 3'h5;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk("word_rst", word_addr, 16'h0000);
        chk("sda_out", 16'(sda_out), 16'h0000);
        m.start_cond();
        chk("busy", 16'(busy), 16'h0001);
        send({addr_dec_pkg::TYPE_ARRAY, strap, 1'b0}, 1'b1);
        chk("sel", 16'(selected), 16'h0001);
        chk("rnw", 16'(rnw), 16'h0000);
        chk("region", 16'(region), 16'(addr_dec_pkg::REGION_ARRAY));
        send(8'hC3, 1'b1);
        send(8'h5A, 1'b1);
        chk("word", word_addr, 16'hC35A);
        chk("valid", 16'(addr_valid), 16'h0001);
        send(8'h11, 1'b1);
        m.stop_cond();
        chk("busy", 16'(busy), 16'h0000);
        chk("sel", 16'(selected), 16'h0000);
        for (int i = 0; i < 8; i++) begin
            m.start_cond();
            send({addr_dec_pkg::TYPE_ARRAY, 3'(i), 1'b0}, 3'(i) == strap);
            send(8'h00, 3'(i) == strap);
            m.stop_cond();
        end
        m.start_cond();
        send({4'h5, strap, 1'b0}, 1'b0);
        m.stop_cond();
        m.start_cond();
        send({addr_dec_pkg::TYPE_ARRAY, strap, 1'b1}, 1'b1);
        chk("rnw", 16'(rnw), 16'h0001);
        chk("valid", 16'(addr_valid), 16'h0001);
        m.stop_cond();
        for (int i = 0; i < 3; i++) begin
            m.start_cond();
            send({addr_dec_pkg::TYPE_SECURE, strap, 1'b0}, 1'b1);
            send(hi_tab[i], 1'b1);
            send(8'h80, 1'b1);
            chk("region", 16'(region), 16'(reg_tab[i]));
            chk("word", word_addr, wa_tab[i]);
            chk("fail", 16'(access_fail), 16'h0000);
            m.stop_cond();
        end
        // Array sequence left open by a repeated start
        m.start_cond();
        send({addr_dec_pkg::TYPE_ARRAY, strap, 1'b0}, 1'b1);
        m.start_cond();
        send({addr_dec_pkg::TYPE_SECURE, strap, 1'b0}, 1'b1);
        send(8'h08, 1'b1);
        send(8'h00, 1'b1);
        chk("fail", 16'(access_fail), 16'h0001);
        m.stop_cond();
        m.start_cond();
        send(8'hF8, 1'b1);
        chk("mfg", 16'(mfg), 16'h0001);
        m.stop_cond();
        chk("mfg", 16'(mfg), 16'h0000);
        m.start_cond();
        send(8'h08, 1'b0);
        chk("hs", 16'(hs), 16'h0001);
        m.start_cond();
        send({addr_dec_pkg::TYPE_ARRAY, strap, 1'b0}, 1'b1);
        m.stop_cond();
        chk("hs", 16'(hs), 16'h0000);
        // Abort half a byte with a fresh start
        m.start_cond();
        for (int i = 0; i < 4; i++) begin
            send_bits_one();
        end
        m.start_cond();
        send({addr_dec_pkg::TYPE_ARRAY, strap, 1'b0}, 1'b1);
        chk("sel", 16'(selected), 16'h0001);
        m.stop_cond();
        give_verdict();
    end

    task automatic send_bits_one();
        logic seen;
        m.put_bit(1'b1, seen);
    endtask

    // Whole sequence is about 3200 cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule
